// >>> verilog/mdf_decimator.sv
`timescale 1ns/1ps
module mdf_decimator (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic mod_tick,
    input wire logic [mdf_pkg::NUM_CH-1:0] mod_bits,
    input wire logic [1:0] mode_sel,
    input wire logic bypass_sel,
    output logic [mdf_pkg::RES_W-1:0] res_data,
    output logic res_valid,
    input wire logic res_ready,
    output logic data_avail,
    output logic settled,
    output logic [mdf_pkg::NUM_CH-1:0] raw_bits,
    output logic overflow
);
    localparam int N = mdf_pkg::NUM_CH;
    localparam int W = mdf_pkg::RES_W;
    localparam int AW = mdf_pkg::ACC_W;
    localparam int CW = mdf_pkg::CNT_W;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [N-1:0] bits_s1;
    logic [N-1:0] bits_s2;
    logic [1:0] tick_s;
    logic tick_d;
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic [1:0] byp_s;
    logic tick;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            bits_s1 <= '0;
            bits_s2 <= '0;
            tick_s <= '0;
            tick_d <= 1'b0;
            mode_s1 <= '0;
            mode_s2 <= '0;
            byp_s <= '0;
        end
        else
        begin
            bits_s1 <= mod_bits;
            bits_s2 <= bits_s1;
            tick_s <= {tick_s[0], mod_tick};
            tick_d <= tick_s[1];
            mode_s1 <= mode_sel;
            mode_s2 <= mode_s1;
            byp_s <= {byp_s[0], bypass_sel};
        end
    end

    // One shared sampling instant for every channel
    assign tick = tick_s[1] && !tick_d;

    // ------------------------------------------------------------
    // Mode tracking and decimation counter
    // ------------------------------------------------------------
    mdf_pkg::mdf_mode_t mode;
    logic mode_chg;
    logic [CW-1:0] dec_cnt;
    logic [CW-1:0] last_cnt;
    logic word_end;

    assign mode_chg = (mode_s2 != mode);
    assign last_cnt = (mode == mdf_pkg::MDF_MODE_HIGH_RES) ?
        mdf_pkg::RATIO_128_LAST :
        mdf_pkg::RATIO_64_LAST;
    assign word_end = tick && (dec_cnt == last_cnt);

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mode <= mdf_pkg::MDF_MODE_HIGH_SPEED;
        end
        else
        begin
            mode <= mdf_pkg::mdf_mode_t'(mode_s2);
        end
    end

    // A single counter serves all channels, so every filter shares
    // one convolution start; restarted on a mode change.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dec_cnt <= '0;
        end
        else if (mode_chg)
        begin
            dec_cnt <= '0;
        end
        else if (tick)
        begin
            dec_cnt <= word_end ? '0 : dec_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Per-channel cascaded filter
    // ------------------------------------------------------------
    // Stage one: boxcar sum over the decimation window. Stage two:
    // two-tap average of successive boxcar words. Both have symmetric
    // taps, so the cascade is linear phase; a full-precision sinc
    // with 100 dB rejection needs a longer cascade than fits here.
    logic signed [W-1:0] chan_res [N];

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_ch
            logic signed [CW+1:0] acc;
            logic signed [CW+1:0] prev;
            logic signed [AW-1:0] scaled;
            logic signed [AW-1:0] sum2;
            logic signed [1:0] bip;

            // One bit maps to +1 or -1: density gives the level
            assign bip = bits_s2[g] ? 2'sb01 : 2'sb11;
            assign sum2 = AW'(acc + bip) + AW'(prev);
            // Scale so full-scale density reaches the 24-bit rails:
            // a full window pair is 2^7 (2^8 in high-res) and must map
            // onto 2^23, so a steady full-scale input clips.
            assign scaled = (mode == mdf_pkg::MDF_MODE_HIGH_RES) ?
                (sum2 <<< 15) : (sum2 <<< 16);

            always_ff @(posedge ref_clk or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    acc <= '0;
                    prev <= '0;
                    chan_res[g] <= '0;
                end
                else if (mode_chg)
                begin
                    acc <= '0;
                    prev <= '0;
                end
                else if (word_end)
                begin
                    acc <= '0;
                    prev <= acc + bip;
                    if (scaled > AW'(signed'(mdf_pkg::SAT_POS)))
                    begin
                        chan_res[g] <= mdf_pkg::SAT_POS;
                    end
                    else if (scaled < AW'(signed'(mdf_pkg::SAT_NEG)))
                    begin
                        chan_res[g] <= mdf_pkg::SAT_NEG;
                    end
                    else
                    begin
                        chan_res[g] <= scaled[W-1:0];
                    end
                end
                else if (tick)
                begin
                    acc <= acc + bip;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Settling counter
    // ------------------------------------------------------------
    logic [7:0] settle_cnt;
    logic [7:0] settle_goal;
    logic out_strobe;

    assign settle_goal = (mode == mdf_pkg::MDF_MODE_HIGH_RES) ?
        mdf_pkg::SETTLE_HR : mdf_pkg::SETTLE_STD;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            settle_cnt <= '0;
            settled <= 1'b0;
        end
        else if (mode_chg)
        begin
            settle_cnt <= '0;
            settled <= 1'b0;
        end
        else if (out_strobe && settle_cnt != settle_goal)
        begin
            settle_cnt <= settle_cnt + 1'b1;
            settled <= (settle_cnt + 1'b1 == settle_goal);
        end
    end

    // ------------------------------------------------------------
    // Word sequencer into the FIFO
    // ------------------------------------------------------------
    // Word one cycle after the window so chan_res is current.
    logic [$clog2(N):0] ch_idx;
    logic sending;
    logic f_in_ready;
    logic f_valid;
    logic [W-1:0] f_data;

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            out_strobe <= 1'b0;
        end
        else
        begin
            out_strobe <= word_end && !byp_s[1];
        end
    end

    assign f_valid = sending;
    assign f_data = chan_res[ch_idx[$clog2(N)-1:0]];

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sending <= 1'b0;
            ch_idx <= '0;
            overflow <= 1'b0;
        end
        else if (out_strobe)
        begin
            // A new window while still sending means the host fell behind
            overflow <= overflow | sending;
            sending <= 1'b1;
            ch_idx <= '0;
        end
        else if (sending && f_in_ready)
        begin
            if (ch_idx == ($clog2(N)+1)'(N - 1))
            begin
                sending <= 1'b0;
            end
            ch_idx <= ch_idx + 1'b1;
        end
    end

    logic fo_valid;
    logic [W-1:0] fo_data;

    mdf_fifo #(
        .WIDTH(mdf_pkg::FIFO_W),
        .DEPTH(mdf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .in_data(f_data),
        .in_valid(f_valid),
        .in_ready(f_in_ready),
        .out_data(fo_data),
        .out_valid(fo_valid),
        .out_ready(res_ready && !(res_valid && !res_ready) && !res_valid)
    );

    // ------------------------------------------------------------
    // Registered outputs toward the serial port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            res_valid <= 1'b0;
            res_data <= '0;
        end
        else if (!res_valid && fo_valid && res_ready)
        begin
            res_valid <= 1'b1;
            res_data <= fo_data;
        end
        else if (res_valid && res_ready)
        begin
            res_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_avail <= 1'b0;
            raw_bits <= '0;
        end
        else
        begin
            data_avail <= fo_valid;
            // Raw bits pass out on every tick in bypass
            if (tick && byp_s[1])
            begin
                raw_bits <= bits_s2;
            end
        end
    end

    // Output rate is modulator rate over 64 (over 128 in high-res); the 144 kSPS ceiling is
    // the feeder's duty to keep mod_tick at or below 9.216 MHz.
    // Stop-band depth of the full product is not met by this cascade.
endmodule : mdf_decimator

// >>> verilog/mdf_pkg.sv
package mdf_pkg;
    // Channel count: four or eight
    localparam int NUM_CH = 8;
    localparam int RES_W = 24;
    localparam int FIFO_W = 24;
    localparam int FIFO_DEPTH = 32;
    localparam int CNT_W = 7;
    localparam int ACC_W = 32;
    localparam logic [CNT_W-1:0] RATIO_64_LAST = 7'h3f;
    localparam logic [CNT_W-1:0] RATIO_128_LAST = 7'h7f;
    localparam logic [RES_W-1:0] SAT_POS = 24'h7fffff;
    localparam logic [RES_W-1:0] SAT_NEG = 24'h800000;
    localparam logic [7:0] SETTLE_STD = 8'h4c;
    localparam logic [7:0] SETTLE_HR = 8'h4e;
    localparam real CLK_MHZ = 20.0;

    typedef enum logic [1:0] {
        MDF_MODE_HIGH_SPEED = 2'b00,
        MDF_MODE_HIGH_RES = 2'b01,
        MDF_MODE_LOW_POWER = 2'b10,
        MDF_MODE_LOW_SPEED = 2'b11
    } mdf_mode_t;
endpackage : mdf_pkg

// >>> verilog/mdf_fifo.sv
`timescale 1ns/1ps
module mdf_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic [AW:0] level;
    logic push;
    logic pop;

    assign level = wr_ptr - rd_ptr;
    assign in_ready = (level != DEPTH[AW:0]);
    assign out_valid = (level != '0);
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : mdf_fifo

// >>> bench/mdf_host_model.sv
`timescale 1ns/1ps
// ----
// Host reader
// ----
module mdf_host_model (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic [mdf_pkg::RES_W-1:0] res_data,
    input wire logic res_valid,
    output logic res_ready
);
    logic [mdf_pkg::RES_W-1:0] words[$];

    initial res_ready = 1'b0;

    // A word counts only at an edge where both sides agree
    always @(posedge ref_clk)
    begin
        if (res_valid && res_ready)
            words.push_back(res_data);
        res_ready <= #1 !stall;
    end
endmodule : mdf_host_model

// >>> bench/mdf_decimator_chk.sv
`timescale 1ns/1ps
module mdf_decimator_chk (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic mod_tick,
    input wire logic [mdf_pkg::NUM_CH-1:0] mod_bits,
    input wire logic [1:0] mode_sel,
    input wire logic bypass_sel,
    input wire logic [mdf_pkg::RES_W-1:0] res_data,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire logic data_avail,
    input wire logic settled,
    input wire logic [mdf_pkg::NUM_CH-1:0] raw_bits,
    input wire logic overflow
);
    logic [4:0] byp_cnt;
    logic [2:0] md_cnt;
    logic [1:0] mode_q;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // ----
    // Settling counters, so that sync latency never trips a check
    // ----
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            byp_cnt <= 5'h00;
        else if (!bypass_sel)
            byp_cnt <= 5'h00;
        else if (byp_cnt != 5'h1f)
            byp_cnt <= byp_cnt + 5'h01;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            md_cnt <= 3'h0;
            mode_q <= 2'h0;
        end
        else
        begin
            mode_q <= mode_sel;
            if (mode_sel != mode_q)
                md_cnt <= 3'h0;
            else if (md_cnt != 3'h7)
                md_cnt <= md_cnt + 3'h1;
        end
    end

    property p_hold;
        res_valid && !res_ready |=> res_valid && $stable(res_data);
    endproperty
    a_hold: assert property (p_hold)
        else $error("word changed while held");
    property p_drop;
        res_valid && res_ready |=> !res_valid;
    endproperty
    a_drop: assert property (p_drop)
        else $error("valid stayed after accept");
    property p_rise;
        $rose(res_valid) |-> $past(res_ready);
    endproperty
    a_rise: assert property (p_rise)
        else $error("valid rose without ready");
    property p_byp;
        byp_cnt == 5'h1f && !data_avail |=> !data_avail;
    endproperty
    a_byp: assert property (p_byp)
        else $error("word made in bypass");
    property p_raw;
        byp_cnt == 5'h1f && $rose(mod_tick) |-> ##[2:8] raw_bits == mod_bits;
    endproperty
    a_raw: assert property (p_raw)
        else $error("raw bits not forwarded");
    property p_mode;
        $changed(mode_sel) |-> ##[1:6] !settled;
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode change kept settled");
    property p_keep;
        md_cnt == 3'h7 && settled |=> settled;
    endproperty
    a_keep: assert property (p_keep)
        else $error("settled fell without cause");
    property p_rst;
        $rose(arst_n) |-> !res_valid && !data_avail && !settled && !overflow;
    endproperty
    a_rst: assert property (p_rst)
        else $error("outputs not clear after reset");

    c_word: cover property (res_valid && res_ready);
    c_settle: cover property ($rose(settled));
    c_raw: cover property ($changed(raw_bits));
endmodule : mdf_decimator_chk

bind mdf_decimator mdf_decimator_chk u_chk (.*);

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk, arst_n, mod_tick, bypass_sel, stall;
    logic [mdf_pkg::NUM_CH-1:0] mod_bits, raw_bits;
    logic [1:0] mode_sel;
    logic [mdf_pkg::RES_W-1:0] res_data;
    logic res_valid, res_ready, data_avail, settled, overflow;
    int err_count = 0;
    int n_compared = 0;

    mdf_decimator dut (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .mod_tick(mod_tick),
        .mod_bits(mod_bits),
        .mode_sel(mode_sel),
        .bypass_sel(bypass_sel),
        .res_data(res_data),
        .res_valid(res_valid),
        .res_ready(res_ready),
        .data_avail(data_avail),
        .settled(settled),
        .raw_bits(raw_bits),
        .overflow(overflow)
    );

    mdf_host_model host (
        .ref_clk(ref_clk),
        .stall(stall),
        .res_data(res_data),
        .res_valid(res_valid),
        .res_ready(res_ready)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // ----
    // Helpers
    // ----
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    // Tick stays 3 cycles per phase, above the one cycle per phase the sync needs
    task automatic tick(input int n);
        repeat (n)
        begin
            mod_tick = 1'b1;
            cyc(3);
            mod_tick = 1'b0;
            cyc(3);
        end
    endtask : tick

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wrap_up;
        $display("errors %0d compares %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    // ----
    // Scenarios
    // ----
    task automatic t_ratio(input logic [1:0] m, input int r);
        mode_sel = m;
        cyc(20);
        chk(settled, 0);
        host.words.delete();
        tick(r - 1);
        cyc(20);
        chk(host.words.size(), 0);
        tick(1);
        cyc(40);
        chk(host.words.size(), 8);
        for (int i = 0; i < 8; i++)
            chk(host.words[i][23], i % 2);
        $display("ratio test mode %0d done", m);
    endtask : t_ratio

    task automatic t_settle;
        tick(74 * 64);
        cyc(40);
        chk(settled, 0);
        tick(64);
        cyc(40);
        chk(settled, 1);
        $display("settle test done");
    endtask : t_settle

    // Four windows stalled fill the buffer to its depth exactly
    task automatic t_stall;
        stall = 1'b1;
        cyc(2);
        host.words.delete();
        tick(4 * 64);
        cyc(40);
        chk(data_avail, 1);
        chk(host.words.size(), 0);
        stall = 1'b0;
        cyc(120);
        chk(host.words.size(), 32);
        chk(overflow, 0);
        chk(data_avail, 0);
        for (int i = 0; i < 32; i++)
            chk(host.words[i][23], i % 2);
        // Steady full-scale windows must clip at the rails
        for (int i = 0; i < 32; i++)
            chk(host.words[i], (i % 2) ? mdf_pkg::SAT_NEG : mdf_pkg::SAT_POS);
        $display("stall test done");
    endtask : t_stall

    task automatic t_bypass;
        bypass_sel = 1'b1;
        mod_bits = 8'ha3;
        cyc(40);
        host.words.delete();
        tick(70);
        cyc(20);
        chk(host.words.size(), 0);
        chk(raw_bits, 8'ha3);
        bypass_sel = 1'b0;
        $display("bypass test done");
    endtask : t_bypass

    initial
    begin
        arst_n = 1'b0;
        mod_tick = 1'b0;
        mod_bits = 8'h55;
        mode_sel = 2'b00;
        bypass_sel = 1'b0;
        stall = 1'b0;
        cyc(2);
        arst_n = 1'b1;
        cyc(4);
        t_ratio(mdf_pkg::MDF_MODE_HIGH_RES, 128);
        t_ratio(mdf_pkg::MDF_MODE_LOW_POWER, 64);
        t_ratio(mdf_pkg::MDF_MODE_LOW_SPEED, 64);
        t_ratio(mdf_pkg::MDF_MODE_HIGH_SPEED, 64);
        t_settle();
        t_stall();
        t_bypass();
        wrap_up();
    end

    initial
    begin
        #(50 * 45000);
        err_count++;
        wrap_up();
    end
endmodule : tb_top
